// ==== inc/ddr3_mpr_pkg.sv ====
// Constants, command codes and carrier types for the DDR3 pattern-readout device model
// Notes on behaviour
// - MRS to mode register 3 with A2 set enters pattern readout mode.
// - In pattern mode every read or read-autoprecharge returns the pattern register.
// - In pattern mode read-autoprecharge acts as plain read, no precharge.
// - With A2 clear, reads and writes use the array whatever location field holds.
// - Pattern bit on bit 0 of each byte lane, bits 7..1 repeat it.
// - Pattern reads ignore bank address, A9..A3, A10, A11 and higher except chop.
// - Full burst returns beats 0..7; chop uses A2 for beats 0..3 or 4..7.
// - Chop works fixed by MR0 or per command via the chop address bit.
// - Pattern reads use ordinary read latency and read timing.
// - Location 00 returns alternating 0,1 beats; burst bit 0 is the LSB.
// - Chip select low with RAS, CAS, WE high is a NOP; bursts continue.
// - Chip select high runs no new command; bursts in progress complete.
// - MR1 A0 set disables the DLL until cleared; changeable at any time.
// - DLL-off supports one read and one write latency, at least six each; the model accepts any CL and CWL code.
// - DLL-off read strobe starts AL+CL-1 cycles after the read.
package ddr3_mpr_pkg;

  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int LAT_W = 5;
  localparam int CNT_W = 8;
  localparam int IDX_W = 4;
  localparam int BEAT_W = 3;
  localparam int MEM_DEPTH = 128;
  localparam int BUF_DEPTH = 2;

  // Mode register selects on the bank address pins
  localparam logic [BA_W-1:0] MR0_SEL = 3'h0;
  localparam logic [BA_W-1:0] MR1_SEL = 3'h1;
  localparam logic [BA_W-1:0] MR2_SEL = 3'h2;
  localparam logic [BA_W-1:0] CAL_MR_SEL = 3'h3;

  // Field positions inside the mode register payload
  localparam int CAL_MPR_EN_BIT = 2;
  localparam int CAL_LOC_LSB = 0;
  localparam int MR1_DLL_OFF_BIT = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_LSB = 4;
  localparam int MR2_CWL_LSB = 3;

  // Address bits read at command time
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int HALF_BIT = 2;
  localparam int COL_LSB = 3;

  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;

  localparam logic [LAT_W-1:0] CL_BASE = 5'h04;
  localparam logic [LAT_W-1:0] CWL_BASE = 5'h05;
  localparam logic [LAT_W-1:0] DLL_OFF_SHIFT = 5'h01;
  localparam logic [LAT_W-1:0] AL_M1 = 5'h01;
  localparam logic [LAT_W-1:0] AL_M2 = 5'h02;

  // Reset values give CL=6, CWL=6, full bursts, DLL on, pattern mode off
  localparam logic [2:0] CL_CODE_RST = 3'h2;
  localparam logic [2:0] CWL_CODE_RST = 3'h1;
  localparam logic [1:0] BL_RST = BL_FIXED8;
  localparam logic [1:0] AL_RST = AL_ZERO;
  localparam logic [1:0] LOC_RST = LOC_PATTERN;

  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam logic [BEAT_W-1:0] HALF_BASE = 3'h4;

  // {ras_n, cas_n, we_n} while chip select is low
  localparam logic [2:0] PINS_MRS = 3'h0;
  localparam logic [2:0] PINS_WRITE = 3'h4;
  localparam logic [2:0] PINS_READ = 3'h5;
  localparam logic [2:0] PINS_NOP = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_DESEL = 3'b001,
    CMD_MRS = 3'b010,
    CMD_READ = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_OTHER = 3'b101
  } cmd_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_s;

  typedef struct packed {
    logic is_write;
    logic chop;
    logic upper;
    logic mpr;
    logic [1:0] loc;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] start;
  } burst_s;

endpackage : ddr3_mpr_pkg

// ==== design/ddr3_mpr_device.sv ====
// DDR3 device model: mode registers, pattern readout, NOP/deselect and DLL-off read latency
`timescale 1ns/1ps
module ddr3_mpr_device
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ddr3_mpr_pkg::BA_W-1:0] ba,
  input wire logic [ddr3_mpr_pkg::ADDR_W-1:0] addr,
  input wire logic [ddr3_mpr_pkg::DQ_W-1:0] dq_in,
  output logic [ddr3_mpr_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic dqs_out,
  output logic dqs_oe_n,
  output logic mpr_mode,
  output logic dll_off,
  output logic auto_precharge,
  output logic cmd_dropped
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
  ddr3_mpr_pkg::cmd_pins_s pins_s1_reg, pins_s2_reg;
  logic [ddr3_mpr_pkg::DQ_W-1:0] dq_s1_reg, dq_s2_reg;

  always_ff @(posedge clk)
  begin
    ck_s1_reg <= ck;
    ck_s2_reg <= ck_s1_reg;
    ck_s3_reg <= ck_s2_reg;
    pins_s1_reg <= '{cs_n, ras_n, cas_n, we_n, ba, addr};
    pins_s2_reg <= pins_s1_reg;
    dq_s1_reg <= dq_in;
    dq_s2_reg <= dq_s1_reg;
  end

  logic rise, fall, edge_any;
  assign rise = ck_s2_reg & ~ck_s3_reg;
  assign fall = ~ck_s2_reg & ck_s3_reg;
  assign edge_any = rise | fall;

  function automatic ddr3_mpr_pkg::cmd_e cmd_decode(input ddr3_mpr_pkg::cmd_pins_s p);
    if (p.cs_n)
      return ddr3_mpr_pkg::CMD_DESEL;
    unique case ({p.ras_n, p.cas_n, p.we_n})
      ddr3_mpr_pkg::PINS_NOP: return ddr3_mpr_pkg::CMD_NOP;
      ddr3_mpr_pkg::PINS_MRS: return ddr3_mpr_pkg::CMD_MRS;
      ddr3_mpr_pkg::PINS_READ: return ddr3_mpr_pkg::CMD_READ;
      ddr3_mpr_pkg::PINS_WRITE: return ddr3_mpr_pkg::CMD_WRITE;
      default: return ddr3_mpr_pkg::CMD_OTHER;
    endcase
  endfunction : cmd_decode

  ddr3_mpr_pkg::cmd_e cur;
  ddr3_mpr_pkg::cmd_pins_s p;
  assign p = pins_s2_reg;
  assign cur = cmd_decode(pins_s2_reg);

  // ---------------------------------------------------------------
  // Mode registers and command intake
  // ---------------------------------------------------------------
  logic mpr_mode_reg, mpr_mode_next, dll_off_reg, dll_off_next;
  logic [1:0] loc_reg, loc_next, bl_reg, bl_next, al_reg, al_next;
  logic [2:0] cl_code_reg, cl_code_next, cwl_code_reg, cwl_code_next;
  logic auto_precharge_reg, auto_precharge_next, cmd_dropped_reg, cmd_dropped_next;
  logic [ddr3_mpr_pkg::CNT_W-1:0] ck_cnt_reg, ck_cnt_next;
  logic [ddr3_mpr_pkg::LAT_W-1:0] cl, al_cyc, rd_lat, wr_lat;
  logic is_rd, is_wr, accept, push, buf_ready, chop;
  ddr3_mpr_pkg::burst_s desc_in;

  always_comb
  begin
    mpr_mode_next = mpr_mode_reg;
    dll_off_next = dll_off_reg;
    loc_next = loc_reg;
    bl_next = bl_reg;
    al_next = al_reg;
    cl_code_next = cl_code_reg;
    cwl_code_next = cwl_code_reg;
    ck_cnt_next = rise ? ck_cnt_reg + 1'b1 : ck_cnt_reg;
    if (rise && cur == ddr3_mpr_pkg::CMD_MRS)
    begin
      unique case (p.ba)
        ddr3_mpr_pkg::MR0_SEL:
        begin
          bl_next = p.addr[ddr3_mpr_pkg::MR0_BL_LSB +: 2];
          cl_code_next = p.addr[ddr3_mpr_pkg::MR0_CL_LSB +: 3];
        end
        ddr3_mpr_pkg::MR1_SEL:
        begin
          dll_off_next = p.addr[ddr3_mpr_pkg::MR1_DLL_OFF_BIT];
          al_next = p.addr[ddr3_mpr_pkg::MR1_AL_LSB +: 2];
        end
        ddr3_mpr_pkg::MR2_SEL: cwl_code_next = p.addr[ddr3_mpr_pkg::MR2_CWL_LSB +: 3];
        ddr3_mpr_pkg::CAL_MR_SEL:
        begin
          mpr_mode_next = p.addr[ddr3_mpr_pkg::CAL_MPR_EN_BIT];
          loc_next = p.addr[ddr3_mpr_pkg::CAL_LOC_LSB +: 2];
        end
        default: ;
      endcase
    end
    cl = ddr3_mpr_pkg::CL_BASE + {2'h0, cl_code_reg};
    unique case (al_reg)
      ddr3_mpr_pkg::AL_CL_M1: al_cyc = cl - ddr3_mpr_pkg::AL_M1;
      ddr3_mpr_pkg::AL_CL_M2: al_cyc = cl - ddr3_mpr_pkg::AL_M2;
      default: al_cyc = '0;
    endcase
    // Pattern reads share this latency; DLL-off moves the strobe one cycle earlier
    rd_lat = al_cyc + cl - (dll_off_reg ? ddr3_mpr_pkg::DLL_OFF_SHIFT : '0);
    wr_lat = al_cyc + ddr3_mpr_pkg::CWL_BASE + {2'h0, cwl_code_reg};
    // NOP, deselect and other codes start nothing; running bursts carry on
    is_rd = rise && cur == ddr3_mpr_pkg::CMD_READ;
    is_wr = rise && cur == ddr3_mpr_pkg::CMD_WRITE && !mpr_mode_reg;
    accept = is_rd || is_wr;
    push = accept && buf_ready;
    chop = bl_reg == ddr3_mpr_pkg::BL_FIXED4 ||
           (bl_reg == ddr3_mpr_pkg::BL_OTF && !p.addr[ddr3_mpr_pkg::BC_BIT]);
    desc_in.is_write = is_wr;
    desc_in.chop = chop;
    desc_in.upper = chop && p.addr[ddr3_mpr_pkg::HALF_BIT];
    desc_in.mpr = mpr_mode_reg;
    desc_in.loc = loc_reg;
    // Bank and upper column bits play no part in a pattern read
    desc_in.idx = mpr_mode_reg ? '0 : p.addr[ddr3_mpr_pkg::COL_LSB +: ddr3_mpr_pkg::IDX_W];
    desc_in.start = ck_cnt_reg + {3'h0, is_wr ? wr_lat : rd_lat};
    // Auto-precharge is dropped while the pattern register is in use
    auto_precharge_next = is_rd && p.addr[ddr3_mpr_pkg::AP_BIT] && !mpr_mode_reg;
    // A full buffer cannot push back on the pins, so the command is lost and flagged
    cmd_dropped_next = cmd_dropped_reg || (accept && !buf_ready);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mpr_mode_reg <= 1'b0;
      dll_off_reg <= 1'b0;
      loc_reg <= ddr3_mpr_pkg::LOC_RST;
      bl_reg <= ddr3_mpr_pkg::BL_RST;
      al_reg <= ddr3_mpr_pkg::AL_RST;
      cl_code_reg <= ddr3_mpr_pkg::CL_CODE_RST;
      cwl_code_reg <= ddr3_mpr_pkg::CWL_CODE_RST;
      auto_precharge_reg <= 1'b0;
      cmd_dropped_reg <= 1'b0;
      ck_cnt_reg <= '0;
    end
    else
    begin
      mpr_mode_reg <= mpr_mode_next;
      dll_off_reg <= dll_off_next;
      loc_reg <= loc_next;
      bl_reg <= bl_next;
      al_reg <= al_next;
      cl_code_reg <= cl_code_next;
      cwl_code_reg <= cwl_code_next;
      auto_precharge_reg <= auto_precharge_next;
      cmd_dropped_reg <= cmd_dropped_next;
      ck_cnt_reg <= ck_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Two-entry burst buffer and data path
  // ---------------------------------------------------------------
  ddr3_mpr_pkg::burst_s buf_reg [ddr3_mpr_pkg::BUF_DEPTH];
  ddr3_mpr_pkg::burst_s head, d, cur_reg, cur_next;
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;
  logic active_reg, active_next, launch, step;
  logic [3:0] beat_reg, beat_next, nbeats;
  logic [ddr3_mpr_pkg::BEAT_W-1:0] b;
  logic [ddr3_mpr_pkg::DQ_W-1:0] mem [ddr3_mpr_pkg::MEM_DEPTH];
  logic [ddr3_mpr_pkg::DQ_W-1:0] dq_out_reg, dq_out_next;
  logic dq_oe_n_reg, dq_oe_n_next, dqs_out_reg, dqs_out_next, dqs_oe_n_reg, dqs_oe_n_next;
  logic mem_we;
  logic [ddr3_mpr_pkg::IDX_W+ddr3_mpr_pkg::BEAT_W-1:0] mem_addr;

  assign head = buf_reg[rd_ptr_reg];
  assign buf_ready = count_reg != 2'h2;

  always_comb
  begin
    // Drain side is ready only when the pins are free; a missed start slot stalls the buffer
    launch = rise && count_reg != 2'h0 && !active_reg && head.start == ck_cnt_reg;
    step = launch || (active_reg && edge_any);
    d = launch ? head : cur_reg;
    nbeats = d.chop ? ddr3_mpr_pkg::BEATS_BC4 : ddr3_mpr_pkg::BEATS_BL8;
    b = (d.upper ? ddr3_mpr_pkg::HALF_BASE : '0) + (launch ? '0 : beat_reg[ddr3_mpr_pkg::BEAT_W-1:0]);
    mem_addr = {d.idx, b};
    mem_we = step && d.is_write;
    wr_ptr_next = push ? ~wr_ptr_reg : wr_ptr_reg;
    rd_ptr_next = launch ? ~rd_ptr_reg : rd_ptr_reg;
    count_next = count_reg + {1'b0, push} - {1'b0, launch};
    cur_next = launch ? head : cur_reg;
    active_next = active_reg;
    beat_next = beat_reg;
    dq_out_next = dq_out_reg;
    dq_oe_n_next = dq_oe_n_reg;
    dqs_out_next = dqs_out_reg;
    dqs_oe_n_next = dqs_oe_n_reg;
    if (step)
    begin
      beat_next = (launch ? 4'h0 : beat_reg) + 4'h1;
      active_next = beat_next != nbeats;
      dq_oe_n_next = d.is_write;
      dqs_oe_n_next = d.is_write;
      dqs_out_next = rise;
      if (d.mpr)
        // Each lane repeats the pattern bit; reserved locations return zero
        dq_out_next = (d.loc == ddr3_mpr_pkg::LOC_PATTERN) ? {ddr3_mpr_pkg::DQ_W{b[0]}} : '0;
      else
        dq_out_next = mem[mem_addr];
    end
    else if (edge_any)
    begin
      dq_oe_n_next = 1'b1;
      dqs_oe_n_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      buf_reg[wr_ptr_reg] <= desc_in;
    if (mem_we)
      mem[mem_addr] <= dq_s2_reg;
    if (sys_rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      cur_reg <= '0;
      active_reg <= 1'b0;
      beat_reg <= 4'h0;
      dq_out_reg <= '0;
      dq_oe_n_reg <= 1'b1;
      dqs_out_reg <= 1'b0;
      dqs_oe_n_reg <= 1'b1;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      cur_reg <= cur_next;
      active_reg <= active_next;
      beat_reg <= beat_next;
      dq_out_reg <= dq_out_next;
      dq_oe_n_reg <= dq_oe_n_next;
      dqs_out_reg <= dqs_out_next;
      dqs_oe_n_reg <= dqs_oe_n_next;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe_n = dq_oe_n_reg;
  assign dqs_out = dqs_out_reg;
  assign dqs_oe_n = dqs_oe_n_reg;
  assign mpr_mode = mpr_mode_reg;
  assign dll_off = dll_off_reg;
  assign auto_precharge = auto_precharge_reg;
  assign cmd_dropped = cmd_dropped_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [ddr3_mpr_pkg::BEAT_W-1:0] b_last_reg;
  always_ff @(posedge clk)
    b_last_reg <= b;

  sequence cal_mr_write_s;
    rise && cur == ddr3_mpr_pkg::CMD_MRS && p.ba == ddr3_mpr_pkg::CAL_MR_SEL;
  endsequence

  sequence mpr_read_s;
    rise && cur == ddr3_mpr_pkg::CMD_READ && mpr_mode_reg;
  endsequence

  mpr_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
    cal_mr_write_s ##0 p.addr[ddr3_mpr_pkg::CAL_MPR_EN_BIT] |=> mpr_mode_reg [*3])
    else $error("pattern mode not entered after mode register write");

  mpr_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    cal_mr_write_s ##0 !p.addr[ddr3_mpr_pkg::CAL_MPR_EN_BIT] |=> !mpr_mode_reg)
    else $error("pattern mode still set after mode register clear");

  mpr_redirect_a: assert property (@(posedge clk) disable iff (sys_rst)
    step && d.mpr |=> dq_out_reg == {ddr3_mpr_pkg::DQ_W{b_last_reg[0]}} || dq_out_reg == '0)
    else $error("pattern read returned array data");

  rda_no_pre_a: assert property (@(posedge clk) disable iff (sys_rst)
    mpr_read_s ##0 p.addr[ddr3_mpr_pkg::AP_BIT] |=> !auto_precharge_reg)
    else $error("precharge issued for pattern read");

  addr_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
    mpr_read_s ##0 push |-> desc_in.idx == '0 && desc_in.upper == (chop && p.addr[ddr3_mpr_pkg::HALF_BIT]))
    else $error("pattern read used ignored address bits");

  lane_pattern_a: assert property (@(posedge clk) disable iff (sys_rst)
    step && d.mpr && d.loc == ddr3_mpr_pkg::LOC_PATTERN |=>
      dq_out_reg[ddr3_mpr_pkg::LANE_W-1:0] == dq_out_reg[ddr3_mpr_pkg::DQ_W-1:ddr3_mpr_pkg::LANE_W] &&
      dq_out_reg[0] == b_last_reg[0] && !dq_oe_n_reg)
    else $error("pattern beat wrong on data lanes");

  burst_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(active_reg) |-> beat_reg == (cur_reg.chop ? ddr3_mpr_pkg::BEATS_BC4 : ddr3_mpr_pkg::BEATS_BL8))
    else $error("burst ended with wrong beat count");

  dll_off_lat_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && !desc_in.is_write && al_reg == ddr3_mpr_pkg::AL_ZERO && cl_code_reg == ddr3_mpr_pkg::CL_CODE_RST |->
      desc_in.start - ck_cnt_reg == (dll_off_reg ? 8'h05 : 8'h06))
    else $error("read start slot does not match latency");

  read_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    launch && !head.is_write |=> !dq_oe_n_reg && !dqs_oe_n_reg && dqs_out_reg)
    else $error("read burst did not drive pins at its slot");

  nop_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    rise && (cur == ddr3_mpr_pkg::CMD_NOP || cur == ddr3_mpr_pkg::CMD_DESEL) |->
      !push ##1 $stable(mpr_mode_reg) && $stable(dll_off_reg) && !auto_precharge_reg)
    else $error("NOP or deselect started a command");

endmodule : ddr3_mpr_device

// ==== testbench/ddr3_ctrl_model.sv ====
// Controller model: makes the DDR clock, issues commands, drives write data, captures read beats
`timescale 1ns/1ps
module ddr3_ctrl_model
(
  input wire logic clk,
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ddr3_mpr_pkg::BA_W-1:0] ba,
  output logic [ddr3_mpr_pkg::ADDR_W-1:0] addr,
  output logic [ddr3_mpr_pkg::DQ_W-1:0] dq_in,
  input wire logic [ddr3_mpr_pkg::DQ_W-1:0] dq_out,
  input wire logic dqs_out,
  input wire logic dqs_oe_n
);
  int phase = 0;
  int edges = 0;
  int rises = 0;
  int cmd_rise = 0;
  int wr_edge0 = -100;
  int lat = 0;
  int k;
  logic oe_seen = 1'b1;
  logic dqs_seen = 1'b0;
  logic [ddr3_mpr_pkg::DQ_W-1:0] beats[$];

  initial
  begin
    ck = 1'b0;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 14'h0000;
    dq_in = 16'h0000;
  end

  // ----------------------------------------
  // Clock, write data and read capture
  // ----------------------------------------
  always @(posedge clk)
  begin
    phase <= (phase + 1) % 4;
    if (phase == 3)
    begin
      ck <= ~ck;
      edges <= edges + 1;
      if (ck == 1'b0)
        rises <= rises + 1;
    end
    // Data moves midway between edges, so it is settled where the device samples it
    k = edges + 1 - wr_edge0;
    if (phase == 1)
      dq_in <= (k >= 0 && k < 8) ? (16'h5A00 | k[15:0]) : ~(16'h5A00 | edges[15:0]);
    // Latency counted in clock rises, so a strobe delay under one period is tolerated
    if (dqs_oe_n === 1'b0 && (oe_seen !== 1'b0 || dqs_out !== dqs_seen))
    begin
      if (oe_seen !== 1'b0)
        lat = rises - cmd_rise;
      beats.push_back(dq_out);
    end
    oe_seen <= dqs_oe_n;
    dqs_seen <= dqs_out;
  end

  // No activate is ever sent, so every bank stays idle before mode register writes
  task automatic issue(input logic [2:0] pins, input logic [2:0] b, input logic [13:0] a);
    @(posedge clk);
    while (!(phase == 3 && ck == 1'b1))
      @(posedge clk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= pins;
    ba <= b;
    addr <= a;
    @(posedge clk);
    while (!(phase == 3 && ck == 1'b0))
      @(posedge clk);
    cmd_rise = rises + 1;
    if (pins == ddr3_mpr_pkg::PINS_WRITE)
      wr_edge0 = edges + 13;
    @(posedge clk);
    while (!(phase == 3 && ck == 1'b1))
      @(posedge clk);
    // Released pins show the inverse of the last command, never a stale copy
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~pins;
    ba <= ~b;
    addr <= ~a;
  endtask : issue
endmodule : ddr3_ctrl_model

// ==== testbench/test_ddr3_mpr_readout_dll_off.sv ====
// Self-checking bench for the DDR3 pattern readout and DLL-off device model
`timescale 1ns/1ps
module test_ddr3_mpr_readout_dll_off;
  logic clk;
  logic sys_rst = 1'b1;
  logic ck, cs_n, ras_n, cas_n, we_n;
  logic [ddr3_mpr_pkg::BA_W-1:0] ba;
  logic [ddr3_mpr_pkg::ADDR_W-1:0] addr;
  logic [ddr3_mpr_pkg::DQ_W-1:0] dq_in, dq_out;
  logic dq_oe_n, dqs_out, dqs_oe_n, mpr_mode, dll_off, auto_precharge, cmd_dropped;
  int fails = 0;
  int compares = 0;
  int seed = 32'h3ad3;
  int cycles = 0;
  logic ap_seen = 1'b0;
  logic [13:0] r;
  logic [3:0] col;
  logic a2, a12;

  ddr3_mpr_device i_ddr3_mpr_device (.clk(clk), .sys_rst(sys_rst), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .mpr_mode(mpr_mode), .dll_off(dll_off),
    .auto_precharge(auto_precharge), .cmd_dropped(cmd_dropped));

  ddr3_ctrl_model i_ddr3_ctrl_model (.clk(clk), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  always @(posedge clk)
  begin
    cycles++;
    if (auto_precharge === 1'b1)
      ap_seen <= 1'b1;
    if (cycles == 6000)
    begin
      fails++;
      test_done();
    end
  end

  function automatic logic [15:0] exp_beat(input bit mpr, input int b);
    if (mpr)
      return b[0] ? 16'hFFFF : 16'h0000;
    return 16'h5A00 | b[15:0];
  endfunction : exp_beat

  task automatic mrs(input logic [2:0] sel, input logic [13:0] val);
    i_ddr3_ctrl_model.issue(ddr3_mpr_pkg::PINS_MRS, sel, val);
    repeat (8) @(posedge clk);
  endtask : mrs

  task automatic rd(input logic [2:0] b, input logic [13:0] a, input int n, input int first, input bit mpr,
    input int rl);
    int k;
    i_ddr3_ctrl_model.beats.delete();
    ap_seen = 1'b0;
    i_ddr3_ctrl_model.issue(ddr3_mpr_pkg::PINS_READ, b, a);
    k = 0;
    while ((i_ddr3_ctrl_model.beats.size() < n || dq_oe_n !== 1'b1) && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    check("burst beats", i_ddr3_ctrl_model.beats.size(), n);
    check("read latency", i_ddr3_ctrl_model.lat, rl);
    for (k = 0; k < n; k++)
      check("read beat", i_ddr3_ctrl_model.beats[k], exp_beat(mpr, first + k));
    check("autoprecharge", ap_seen, !mpr && a[10]);
  endtask : rd

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("reset flags", {mpr_mode, dll_off, cmd_dropped, dq_oe_n, dqs_oe_n}, 5'h03);
    col = 4'($random(seed));
    i_ddr3_ctrl_model.issue(ddr3_mpr_pkg::PINS_WRITE, 3'($random(seed)), {7'h00, col, 3'h0});
    repeat (80) @(posedge clk);
    rd(3'h5, {3'h1, 4'h0, col, 3'h0}, 8, 0, 1'b0, 6);
    // A no-operation, then a deselected mode register write that would enable pattern mode
    i_ddr3_ctrl_model.issue(ddr3_mpr_pkg::PINS_NOP, 3'h4, 14'h3FFB);
    repeat (12) @(posedge clk);
    check("nop deselect", mpr_mode, 1'b0);
    mrs(ddr3_mpr_pkg::MR0_SEL, 14'h0022);
    // The DLL stays on and locked for every pattern read
    mrs(ddr3_mpr_pkg::CAL_MR_SEL, 14'h0004);
    check("pattern mode on", mpr_mode, 1'b1);
    rd(3'h7, 14'h07FC, 4, 4, 1'b1, 6);
    mrs(ddr3_mpr_pkg::CAL_MR_SEL, 14'h0003);
    mrs(ddr3_mpr_pkg::MR0_SEL, 14'h0021);
    mrs(ddr3_mpr_pkg::CAL_MR_SEL, 14'h0004);
    rd(3'h7, 14'h17F8, 8, 0, 1'b1, 6);
    // Only reads while pattern mode is on; the low address pair stays zero
    for (int i = 0; i < 8; i++)
    begin
      r = 14'($random(seed));
      a12 = r[12];
      a2 = a12 ? 1'b0 : r[2];
      rd(3'($random(seed)), {r[13], a12, r[11:3], a2, 2'h0}, a12 ? 8 : 4, a2 ? 4 : 0, 1'b1, 6);
    end
    mrs(ddr3_mpr_pkg::CAL_MR_SEL, 14'h0003);
    check("pattern mode off", mpr_mode, 1'b0);
    // A10 set: outside pattern mode the precharge pulse must appear
    rd(3'h2, {3'h2, 4'h8, col, 3'h0}, 8, 0, 1'b0, 6);
    mrs(ddr3_mpr_pkg::MR1_SEL, 14'h0001);
    check("dll off", dll_off, 1'b1);
    rd(3'h0, {3'h2, 4'h0, col, 3'h0}, 8, 0, 1'b0, 5);
    mrs(ddr3_mpr_pkg::MR1_SEL, 14'h0000);
    check("dll on", dll_off, 1'b0);
    // Additive latency CL-1 gives a read latency of 5 + 6
    mrs(ddr3_mpr_pkg::MR1_SEL, 14'h0008);
    rd(3'h1, {3'h2, 4'h0, col, 3'h0}, 8, 0, 1'b0, 11);
    mrs(ddr3_mpr_pkg::MR1_SEL, 14'h0000);
    // Three reads two clocks apart overfill the two-entry queue
    for (int i = 0; i < 3; i++)
      i_ddr3_ctrl_model.issue(ddr3_mpr_pkg::PINS_READ, 3'h0, {3'h2, 4'h0, col, 3'h0});
    repeat (200) @(posedge clk);
    check("dropped", cmd_dropped, 1'b1);
    check("drained", {dq_oe_n, dqs_oe_n}, 2'h3);
    test_done();
  end
endmodule : test_ddr3_mpr_readout_dll_off
